// ==== src/bmpc_defs.svh ====
// constants of the burst mode and protection controller
`ifndef BMPC_DEFS_SVH
`define BMPC_DEFS_SVH

`define BMPC_CLK_MHZ 250
`define BMPC_CNT_W 23
`define BMPC_VALLEY_W 3
`define BMPC_VALLEY_BURST 3'h7
`define BMPC_VALLEY_RESTART 3'h1

// times in their own unit
`define BMPC_ENTRY_MS 24
`define BMPC_OVERLOAD_MS 30
`define BMPC_VCC_OVP_US 10
`define BMPC_ZC_OVP_US 100
`define BMPC_SHORT_WIND_NS 190
`define BMPC_LEB_NS 330
`define BMPC_MAX_ON_US 30
`define BMPC_BURST_KHZ 52
`define BMPC_BURST_DUTY_PCT 50

// cycle counts; least times round up, longest and periods round down
`define BMPC_ENTRY_CYC (`BMPC_ENTRY_MS * 1000 * `BMPC_CLK_MHZ)
`define BMPC_OVERLOAD_CYC (`BMPC_OVERLOAD_MS * 1000 * `BMPC_CLK_MHZ)
`define BMPC_VCC_OVP_CYC (`BMPC_VCC_OVP_US * `BMPC_CLK_MHZ)
`define BMPC_ZC_OVP_CYC (`BMPC_ZC_OVP_US * `BMPC_CLK_MHZ)
`define BMPC_SHORT_WIND_CYC ((`BMPC_SHORT_WIND_NS * `BMPC_CLK_MHZ + 999) / 1000)
`define BMPC_LEB_CYC ((`BMPC_LEB_NS * `BMPC_CLK_MHZ + 999) / 1000)
`define BMPC_MAX_ON_CYC (`BMPC_MAX_ON_US * `BMPC_CLK_MHZ)
`define BMPC_BURST_PERIOD_CYC (`BMPC_CLK_MHZ * 1000 / `BMPC_BURST_KHZ)

`define BMPC_NUM_TIMERS 5
`define BMPC_NUM_FLAGS 14

`endif

// ==== src/bmpc_pkg.sv ====
// types of the burst mode and protection controller
package bmpc_pkg;

	typedef enum logic [2:0] {
		ST_WAIT_DROP,
		ST_CHARGE,
		ST_NORMAL,
		ST_BURST_PAUSE,
		ST_BURST_RUN,
		ST_LATCH_DROP,
		ST_LATCH_CHARGE
	} bmpc_state_type;

	typedef enum int {
		TMR_ENTRY = 0,
		TMR_OVERLOAD = 1,
		TMR_VCC_OVP = 2,
		TMR_ZC_OVP = 3,
		TMR_SHORT_WIND = 4
	} bmpc_timer_type;

endpackage

// ==== src/bmpc_timer_if.sv ====
// qualification timer hookup
`timescale 1ns/1ps
`include "bmpc_defs.svh"

interface bmpc_timer_if;
	logic flag;
	logic [`BMPC_CNT_W-1:0] limit;
	logic expired;
	modport timer (input flag, input limit, output expired);
	modport user (output flag, output limit, input expired);
endinterface // bmpc_timer_if

// ==== src/bmpc_qual_timer.sv ====
// qualification timer: flag held for limit cycles
`timescale 1ns/1ps
`include "bmpc_defs.svh"

module bmpc_qual_timer (
	input wire logic clk,
	input wire logic srst,
	bmpc_timer_if.timer tif
);
	logic [`BMPC_CNT_W-1:0] count;

	// restart whenever the flag drops
	always_ff @(posedge clk) begin
		if (srst || !tif.flag) begin
			count <= '0; // RULE22
		end else if (count != tif.limit) begin
			count <= count + `BMPC_CNT_W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			tif.expired <= 1'b0;
		end else begin
			tif.expired <= tif.flag &&
				(count >= tif.limit - `BMPC_CNT_W'(1)); // RULE22
		end
	end
endmodule // bmpc_qual_timer

// ==== src/bmpc_ctrl.sv ====
// burst mode and protection controller top
// Function
// RULE1 - enter burst: feedback below entry, valley count seven, blanking elapsed
// RULE2 - paused burst resumes switching and bias when feedback exceeds resume level
// RULE3 - burst turn-on comes from fixed-frequency timer, not valleys
// RULE4 - burst on-pulse ends at reduced burst current limit
// RULE5 - burst on-pulse also ends at half period; first one wins
// RULE6 - feedback at pause level resets bias and stops switching
// RULE7 - feedback above exit level leaves burst, restoring full current limit
// RULE8 - leaving burst loads valley counter with one at once
// RULE9 - supply under or over voltage resets logic, switch held off; code resets at once only on under voltage, over voltage via RULE11
// RULE10 - after supply reset: cell on below turn-off, restart above turn-on
// RULE11 - supply overvoltage held ten microseconds in normal mode: auto-restart
// RULE12 - overload flag held thirty milliseconds: auto-restart
// RULE13 - overload protection and its timer suppressed during burst
// RULE14 - zero-cross overvoltage in off-time held blanking time: latch off
// RULE15 - latch released only by supply below power-down level
// RULE16 - over-temperature flag causes auto-restart
// RULE17 - over-temperature flag ignored during burst
// RULE18 - short-winding flag in on-time held blanking time: latch off
// RULE19 - short-winding flag ignored during burst
// RULE20 - latched: cell cycles with supply levels, switch always off
// RULE21 - gate forced low once high longer than maximum on-time
// RULE22 - comparator flags synchronised; blanking counters restart when flag drops
`timescale 1ns/1ps
`include "bmpc_defs.svh"

module bmpc_ctrl #(
	parameter logic [`BMPC_CNT_W-1:0] ENTRY_CYC = `BMPC_CNT_W'(`BMPC_ENTRY_CYC),
	parameter logic [`BMPC_CNT_W-1:0] OVERLOAD_CYC =
		`BMPC_CNT_W'(`BMPC_OVERLOAD_CYC),
	parameter logic [`BMPC_CNT_W-1:0] ZC_OVP_CYC =
		`BMPC_CNT_W'(`BMPC_ZC_OVP_CYC),
	parameter logic [`BMPC_CNT_W-1:0] MAX_ON_CYC =
		`BMPC_CNT_W'(`BMPC_MAX_ON_CYC),
	parameter logic [`BMPC_CNT_W-1:0] BURST_PERIOD_CYC =
		`BMPC_CNT_W'(`BMPC_BURST_PERIOD_CYC)
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic fb_below_entry,
	input wire logic fb_above_resume,
	input wire logic fb_below_pause,
	input wire logic fb_above_exit,
	input wire logic cs_above_regulation,
	input wire logic cs_above_burst_limit,
	input wire logic cs_above_short_winding,
	input wire logic zc_above_ovp,
	input wire logic vcc_over,
	input wire logic vcc_below_turnoff,
	input wire logic vcc_above_turnon,
	input wire logic vcc_below_powerdown,
	input wire logic over_temp,
	input wire logic valley_turn_on,
	input wire logic [`BMPC_VALLEY_W-1:0] valley_count,
	output logic gate_drive,
	output logic burst_active,
	output logic bias_enable,
	output logic full_current_limit,
	output logic valley_load_one,
	output logic startup_cell_en,
	output logic soft_start_req,
	output logic latched_off
);
	//****************************************
	// input synchroniser
	//****************************************
	logic [`BMPC_NUM_FLAGS-1:0] raw;
	logic [`BMPC_NUM_FLAGS-1:0] meta;
	logic [`BMPC_NUM_FLAGS-1:0] sync;
	logic [`BMPC_VALLEY_W-1:0] valley_meta;
	logic [`BMPC_VALLEY_W-1:0] valley_sync;

	assign raw = {valley_turn_on, over_temp, vcc_below_powerdown,
		vcc_above_turnon, vcc_below_turnoff, vcc_over, zc_above_ovp,
		cs_above_short_winding, cs_above_burst_limit, cs_above_regulation,
		fb_above_exit, fb_below_pause, fb_above_resume, fb_below_entry};

	genvar gi;
	generate
		for (gi = 0; gi < `BMPC_NUM_FLAGS; gi++) begin : g_sync
			always_ff @(posedge clk) begin
				if (srst) begin
					meta[gi] <= 1'b0;
					sync[gi] <= 1'b0;
				end else begin
					meta[gi] <= raw[gi]; // RULE22
					sync[gi] <= meta[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (srst) begin
			valley_meta <= '0;
			valley_sync <= '0;
		end else begin
			valley_meta <= valley_count;
			valley_sync <= valley_meta;
		end
	end

	logic s_fb_entry, s_fb_resume, s_fb_pause, s_fb_exit;
	logic s_cs_reg, s_cs_burst, s_cs_sw, s_zc_ovp, s_vcc_over;
	logic s_vcc_low, s_vcc_on, s_vcc_pd, s_temp, s_valley_on;
	assign {s_valley_on, s_temp, s_vcc_pd, s_vcc_on, s_vcc_low, s_vcc_over,
		s_zc_ovp, s_cs_sw, s_cs_burst, s_cs_reg, s_fb_exit, s_fb_pause,
		s_fb_resume, s_fb_entry} = sync;

	//****************************************
	// state decode
	//****************************************
	bmpc_pkg::bmpc_state_type state;
	bmpc_pkg::bmpc_state_type next_state;

	function automatic logic in_burst(input bmpc_pkg::bmpc_state_type s);
		return (s == bmpc_pkg::ST_BURST_PAUSE) ||
			(s == bmpc_pkg::ST_BURST_RUN);
	endfunction

	function automatic logic running(input bmpc_pkg::bmpc_state_type s);
		return (s == bmpc_pkg::ST_NORMAL) || in_burst(s);
	endfunction

	//****************************************
	// qualification timers
	//****************************************
	bmpc_timer_if tif [`BMPC_NUM_TIMERS] ();
	logic [`BMPC_NUM_TIMERS-1:0] expired;

	assign tif[bmpc_pkg::TMR_ENTRY].flag = (state == bmpc_pkg::ST_NORMAL) &&
		s_fb_entry && (valley_sync == `BMPC_VALLEY_BURST); // RULE1
	assign tif[bmpc_pkg::TMR_ENTRY].limit = ENTRY_CYC;
	assign tif[bmpc_pkg::TMR_OVERLOAD].flag =
		(state == bmpc_pkg::ST_NORMAL) && s_fb_exit; // RULE12 RULE13
	assign tif[bmpc_pkg::TMR_OVERLOAD].limit = OVERLOAD_CYC;
	assign tif[bmpc_pkg::TMR_VCC_OVP].flag =
		(state == bmpc_pkg::ST_NORMAL) && s_vcc_over; // RULE11
	assign tif[bmpc_pkg::TMR_VCC_OVP].limit =
		`BMPC_CNT_W'(`BMPC_VCC_OVP_CYC);
	assign tif[bmpc_pkg::TMR_ZC_OVP].flag =
		running(state) && !gate_drive && s_zc_ovp; // RULE14
	assign tif[bmpc_pkg::TMR_ZC_OVP].limit = ZC_OVP_CYC;
	assign tif[bmpc_pkg::TMR_SHORT_WIND].flag =
		(state == bmpc_pkg::ST_NORMAL) && gate_drive && s_cs_sw; // RULE18 RULE19
	assign tif[bmpc_pkg::TMR_SHORT_WIND].limit =
		`BMPC_CNT_W'(`BMPC_SHORT_WIND_CYC);

	generate
		for (gi = 0; gi < `BMPC_NUM_TIMERS; gi++) begin : g_tmr
			bmpc_qual_timer u_tmr (
				.clk(clk),
				.srst(srst),
				.tif(tif[gi])
			);
			assign expired[gi] = tif[gi].expired;
		end
	endgenerate

	logic auto_restart;
	logic latch_fault;
	assign auto_restart = expired[bmpc_pkg::TMR_OVERLOAD] || // RULE12
		expired[bmpc_pkg::TMR_VCC_OVP] || // RULE11
		(s_temp && !in_burst(state)); // RULE16 RULE17
	assign latch_fault = expired[bmpc_pkg::TMR_ZC_OVP] || // RULE14
		expired[bmpc_pkg::TMR_SHORT_WIND]; // RULE18

	//****************************************
	// main state machine
	//****************************************
	always_comb begin
		next_state = state;
		case (state)
			bmpc_pkg::ST_WAIT_DROP: begin
				if (s_vcc_low) begin
					next_state = bmpc_pkg::ST_CHARGE; // RULE10
				end
			end
			bmpc_pkg::ST_CHARGE: begin
				if (s_vcc_on && !s_vcc_low) begin
					next_state = bmpc_pkg::ST_NORMAL; // RULE10
				end
			end
			bmpc_pkg::ST_NORMAL, bmpc_pkg::ST_BURST_PAUSE,
			bmpc_pkg::ST_BURST_RUN: begin
				if (s_vcc_low) begin
					next_state = bmpc_pkg::ST_CHARGE; // RULE9
				end else if (latch_fault) begin
					next_state = bmpc_pkg::ST_LATCH_DROP;
				end else if (auto_restart) begin
					next_state = bmpc_pkg::ST_WAIT_DROP; // RULE9
				end else if (state == bmpc_pkg::ST_NORMAL) begin
					if (expired[bmpc_pkg::TMR_ENTRY]) begin
						next_state = bmpc_pkg::ST_BURST_PAUSE; // RULE1
					end
				end else if (s_fb_exit) begin
					next_state = bmpc_pkg::ST_NORMAL; // RULE7
				end else if (state == bmpc_pkg::ST_BURST_PAUSE) begin
					if (s_fb_resume) begin
						next_state = bmpc_pkg::ST_BURST_RUN; // RULE2
					end
				end else if (s_fb_pause) begin
					next_state = bmpc_pkg::ST_BURST_PAUSE; // RULE6
				end
			end
			bmpc_pkg::ST_LATCH_DROP: begin
				if (s_vcc_pd) begin
					next_state = bmpc_pkg::ST_CHARGE; // RULE15
				end else if (s_vcc_low) begin
					next_state = bmpc_pkg::ST_LATCH_CHARGE; // RULE20
				end
			end
			bmpc_pkg::ST_LATCH_CHARGE: begin
				if (s_vcc_pd) begin
					next_state = bmpc_pkg::ST_CHARGE; // RULE15
				end else if (s_vcc_on) begin
					next_state = bmpc_pkg::ST_LATCH_DROP; // RULE20
				end
			end
			default: begin
				next_state = bmpc_pkg::ST_CHARGE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state <= bmpc_pkg::ST_CHARGE;
		end else begin
			state <= next_state;
		end
	end

	//****************************************
	// burst timer and on-time counter
	//****************************************
	logic [`BMPC_CNT_W-1:0] burst_cnt;
	logic [`BMPC_CNT_W-1:0] on_cnt;
	logic burst_tick;
	logic duty_limit;
	logic leb_done;
	logic max_on;

	always_ff @(posedge clk) begin
		if (srst || next_state != bmpc_pkg::ST_BURST_RUN ||
			burst_cnt == BURST_PERIOD_CYC - `BMPC_CNT_W'(1)) begin
			burst_cnt <= '0; // RULE3
		end else begin
			burst_cnt <= burst_cnt + `BMPC_CNT_W'(1);
		end
	end

	assign burst_tick = (state == bmpc_pkg::ST_BURST_RUN) &&
		(burst_cnt == '0); // RULE3
	assign duty_limit = burst_cnt >= `BMPC_CNT_W'(BURST_PERIOD_CYC *
		`BMPC_BURST_DUTY_PCT / 100) - `BMPC_CNT_W'(1); // RULE5

	always_ff @(posedge clk) begin
		if (srst || !gate_drive) begin
			on_cnt <= '0;
		end else if (on_cnt != MAX_ON_CYC) begin
			on_cnt <= on_cnt + `BMPC_CNT_W'(1);
		end
	end

	assign leb_done = on_cnt >= `BMPC_CNT_W'(`BMPC_LEB_CYC);
	assign max_on = on_cnt >= MAX_ON_CYC - `BMPC_CNT_W'(1); // RULE21

	//****************************************
	// gate drive
	//****************************************
	logic next_gate;

	always_comb begin
		next_gate = gate_drive;
		if (!running(next_state) || !running(state) ||
			next_state == bmpc_pkg::ST_BURST_PAUSE) begin
			next_gate = 1'b0; // RULE9 RULE20 RULE6
		end else if (gate_drive) begin
			if (max_on) begin
				next_gate = 1'b0; // RULE21
			end else if (state == bmpc_pkg::ST_NORMAL) begin
				next_gate = !(leb_done && s_cs_reg);
			end else begin
				next_gate = !((leb_done && s_cs_burst) || // RULE4
					duty_limit || !in_burst(next_state)); // RULE5
			end
		end else if (state == bmpc_pkg::ST_NORMAL &&
			next_state == bmpc_pkg::ST_NORMAL) begin
			next_gate = s_valley_on;
		end else if (next_state == bmpc_pkg::ST_BURST_RUN) begin
			next_gate = burst_tick; // RULE3
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			gate_drive <= 1'b0;
		end else begin
			gate_drive <= next_gate;
		end
	end

	//****************************************
	// status outputs
	//****************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			burst_active <= 1'b0;
			bias_enable <= 1'b0;
			full_current_limit <= 1'b1;
			valley_load_one <= 1'b0;
			startup_cell_en <= 1'b1;
			soft_start_req <= 1'b0;
			latched_off <= 1'b0;
		end else begin
			burst_active <= in_burst(next_state);
			bias_enable <= (next_state == bmpc_pkg::ST_NORMAL) ||
				(next_state == bmpc_pkg::ST_BURST_RUN); // RULE2 RULE6
			full_current_limit <= !in_burst(next_state); // RULE7
			valley_load_one <= in_burst(state) &&
				(next_state == bmpc_pkg::ST_NORMAL); // RULE8
			startup_cell_en <= (next_state == bmpc_pkg::ST_CHARGE) ||
				(next_state == bmpc_pkg::ST_LATCH_CHARGE); // RULE10 RULE20
			soft_start_req <= (state == bmpc_pkg::ST_CHARGE) &&
				(next_state == bmpc_pkg::ST_NORMAL); // RULE10
			latched_off <= (next_state == bmpc_pkg::ST_LATCH_DROP) ||
				(next_state == bmpc_pkg::ST_LATCH_CHARGE); // RULE15
		end
	end
endmodule // bmpc_ctrl

// ==== dv/bmpc_stage_model.sv ====
// power stage model: current sense ramp during on-time
`timescale 1ns/1ps

module bmpc_stage_model (
	input wire logic clk,
	input wire logic gate_drive,
	input wire logic [15:0] cs_delay,
	output logic cs_flag
);
	logic [15:0] on_cnt;

	// zero delay: current never reaches the limit
	always_ff @(posedge clk) begin
		if (!gate_drive) begin
			on_cnt <= 16'h0;
			cs_flag <= 1'h0;
		end else begin
			on_cnt <= on_cnt + 16'h1;
			cs_flag <= (cs_delay != 16'h0) && (on_cnt >= cs_delay);
		end
	end
endmodule // bmpc_stage_model

// ==== dv/bmpc_ctrl_props.sv ====
// assertions on the controller ports
`timescale 1ns/1ps
`include "bmpc_defs.svh"

module bmpc_ctrl_props #(
	parameter logic [`BMPC_CNT_W-1:0] MAX_ON_CYC = 23'h1D4C,
	parameter logic [`BMPC_CNT_W-1:0] BURST_PERIOD_CYC = 23'h12C7
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic vcc_below_powerdown,
	input wire logic gate_drive,
	input wire logic burst_active,
	input wire logic bias_enable,
	input wire logic full_current_limit,
	input wire logic valley_load_one,
	input wire logic startup_cell_en,
	input wire logic soft_start_req,
	input wire logic latched_off
);
	logic [`BMPC_CNT_W-1:0] gate_hi_cnt;

	// cycles the gate has stayed high
	always_ff @(posedge clk) begin
		if (srst || !gate_drive) begin
			gate_hi_cnt <= '0;
		end else begin
			gate_hi_cnt <= gate_hi_cnt + 23'h1;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	a_reset_outputs: assert property (disable iff (1'h0)
		srst |=> !gate_drive && !bias_enable && startup_cell_en && !latched_off)
		else $error("outputs wrong after reset");
	a_max_on_time: assert property (gate_hi_cnt <= MAX_ON_CYC)
		else $error("gate high beyond maximum on-time");
	a_burst_duty: assert property (
		burst_active && gate_drive |-> gate_hi_cnt <= BURST_PERIOD_CYC / 23'h2)
		else $error("burst pulse beyond half period");
	a_latch_gate_off: assert property (
		latched_off |-> !gate_drive && !bias_enable)
		else $error("gate active while latched");
	a_pause_no_gate: assert property (
		burst_active && !bias_enable |-> !gate_drive)
		else $error("gate active in burst pause");
	a_gate_needs_bias: assert property (gate_drive |-> bias_enable)
		else $error("gate active without bias");
	a_exit_restores: assert property (
		$fell(burst_active) && bias_enable |->
		full_current_limit && valley_load_one)
		else $error("burst exit without limit restore or counter load");
	a_burst_limit_low: assert property (
		burst_active |-> !full_current_limit)
		else $error("full current limit during burst");
	a_latch_release: assert property (
		$fell(latched_off) && !$past(srst) |-> $past(vcc_below_powerdown) ||
		$past(vcc_below_powerdown, 2) || $past(vcc_below_powerdown, 3) ||
		$past(vcc_below_powerdown, 4) || $past(vcc_below_powerdown, 5))
		else $error("latch released without power-down");
	a_soft_start_one: assert property (soft_start_req |=> !soft_start_req)
		else $error("soft start request longer than one cycle");
endmodule // bmpc_ctrl_props

bind bmpc_ctrl bmpc_ctrl_props #(
	.MAX_ON_CYC(MAX_ON_CYC),
	.BURST_PERIOD_CYC(BURST_PERIOD_CYC)
) bmpc_ctrl_props_inst (
	.clk(clk), .srst(srst), .vcc_below_powerdown(vcc_below_powerdown),
	.gate_drive(gate_drive), .burst_active(burst_active),
	.bias_enable(bias_enable), .full_current_limit(full_current_limit),
	.valley_load_one(valley_load_one), .startup_cell_en(startup_cell_en),
	.soft_start_req(soft_start_req), .latched_off(latched_off)
);

// ==== dv/burst_mode_protection_ctrl_tb_top.sv ====
// testbench of the burst mode and protection controller
`timescale 1ns/1ps

module burst_mode_protection_ctrl_tb_top;
	// ****************
	// hookup
	// ****************
	logic clk = 1'h0;
	logic srst = 1'h1;
	logic fe, fr, fp, fx, csw, zc, vo, vt, vn, vpd, ot, vto;
	logic [2:0] vc;
	logic [15:0] dly;
	wire logic csf, gate_drive, burst_active, bias_enable, full_current_limit;
	wire logic valley_load_one, startup_cell_en, soft_start_req, latched_off;
	int error_cnt = 0;
	int checks = 0;
	int hi, per;

	always #2 clk = ~clk;

	bmpc_stage_model bmpc_stage_model_inst (.clk(clk),
		.gate_drive(gate_drive), .cs_delay(dly), .cs_flag(csf));

	bmpc_ctrl #(.ENTRY_CYC(23'h32), .OVERLOAD_CYC(23'h3C),
		.ZC_OVP_CYC(23'h28), .MAX_ON_CYC(23'h12C),
		.BURST_PERIOD_CYC(23'h12C)) bmpc_ctrl_inst (
		.clk(clk), .srst(srst), .fb_below_entry(fe), .fb_above_resume(fr),
		.fb_below_pause(fp), .fb_above_exit(fx), .cs_above_regulation(csf),
		.cs_above_burst_limit(csf), .cs_above_short_winding(csw),
		.zc_above_ovp(zc), .vcc_over(vo), .vcc_below_turnoff(vt),
		.vcc_above_turnon(vn), .vcc_below_powerdown(vpd), .over_temp(ot),
		.valley_turn_on(vto), .valley_count(vc), .gate_drive(gate_drive),
		.burst_active(burst_active), .bias_enable(bias_enable),
		.full_current_limit(full_current_limit),
		.valley_load_one(valley_load_one), .startup_cell_en(startup_cell_en),
		.soft_start_req(soft_start_req), .latched_off(latched_off));

	// ****************
	// scenarios
	// ****************
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task chk(input logic g, input logic w);
		checks++;
		if (g !== w) begin
			error_cnt++;
			$display("unexpected %0t check %0d mismatch", $time, checks);
		end
	endtask

	task end_sim;
		if (error_cnt == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task pulse;
		hi = 0;
		per = 0;
		while (gate_drive !== 1'h1 && per < 2000) begin
			cyc(1);
			per++;
		end
		while (gate_drive === 1'h1) begin
			cyc(1);
			hi++;
		end
		per = hi;
		while (gate_drive !== 1'h1 && per < 2000) begin
			cyc(1);
			per++;
		end
	endtask

	task up;
		int s;
		s = 0;
		vn <= 1'h1;
		repeat (8) begin
			cyc(1);
			if (soft_start_req === 1'h1) s++;
		end
		chk(s == 1, 1'h1);
		chk(bias_enable, 1'h1);
	endtask

	task recover;
		vn <= 1'h0;
		vt <= 1'h1;
		cyc(6);
		chk(startup_cell_en, 1'h1);
		chk(gate_drive | bias_enable, 1'h0);
		vt <= 1'h0;
		up();
	endtask

	task t_burst;
		int s;
		vc <= 3'h6;
		fe <= 1'h1;
		cyc(70);
		chk(burst_active, 1'h0);
		vc <= 3'h7;
		cyc(60);
		chk(burst_active, 1'h1);
		chk(full_current_limit | bias_enable, 1'h0);
		fe <= 1'h0;
		ot <= 1'h1;
		csw <= 1'h1;
		fr <= 1'h1;
		cyc(6);
		chk(bias_enable, 1'h1);
		pulse();
		pulse();
		chk(hi >= 145 && hi <= 152, 1'h1);
		chk(per == 300, 1'h1);
		dly <= 16'h64;
		pulse();
		pulse();
		chk(hi >= 98 && hi <= 110, 1'h1);
		chk(burst_active & ~latched_off, 1'h1);
		ot <= 1'h0;
		csw <= 1'h0;
		fr <= 1'h0;
		fp <= 1'h1;
		cyc(160);
		s = 0;
		repeat (400) begin
			cyc(1);
			if (gate_drive !== 1'h0 || bias_enable !== 1'h0) s++;
		end
		chk(s == 0, 1'h1);
		fp <= 1'h0;
		fx <= 1'h1;
		s = 0;
		repeat (8) begin
			cyc(1);
			if (valley_load_one === 1'h1) s++;
		end
		fx <= 1'h0;
		chk(s == 1, 1'h1);
		chk(full_current_limit & ~burst_active, 1'h1);
	endtask

	task t_faults;
		repeat (2) begin
			fx <= 1'h1;
			cyc(40);
			fx <= 1'h0;
			cyc(5);
			chk(bias_enable, 1'h1);
		end
		fx <= 1'h1;
		cyc(70);
		fx <= 1'h0;
		chk(bias_enable | startup_cell_en, 1'h0);
		recover();
		ot <= 1'h1;
		cyc(6);
		ot <= 1'h0;
		chk(bias_enable, 1'h0);
		recover();
		vo <= 1'h1;
		cyc(2400);
		chk(bias_enable, 1'h1);
		cyc(200);
		vo <= 1'h0;
		chk(bias_enable, 1'h0);
		recover();
	endtask

	task latch(input logic sw);
		dly <= 16'h0;
		csw <= sw;
		vto <= sw;
		zc <= ~sw;
		cyc(80);
		{csw, vto, zc} <= 3'h0;
		chk(latched_off, 1'h1);
		vn <= 1'h0;
		vt <= 1'h1;
		cyc(6);
		chk(startup_cell_en, 1'h1);
		vt <= 1'h0;
		vn <= 1'h1;
		cyc(6);
		chk(startup_cell_en | gate_drive, 1'h0);
		chk(latched_off, 1'h1);
		vpd <= 1'h1;
		vt <= 1'h1;
		vn <= 1'h0;
		cyc(6);
		vpd <= 1'h0;
		chk(latched_off, 1'h0);
		vt <= 1'h0;
		up();
	endtask

	initial begin
		{fe, fr, fp, fx, csw, zc, vo, vt, vn, vpd, ot, vto} = '0;
		vc = 3'h0;
		dly = 16'h0;
		repeat (12) @(posedge clk);
		srst <= 1'h0;
		cyc(2);
		chk(gate_drive | bias_enable | latched_off, 1'h0);
		chk(startup_cell_en & full_current_limit, 1'h1);
		up();
		vto <= 1'h1;
		pulse();
		chk(hi >= 295 && hi <= 305, 1'h1);
		vto <= 1'h0;
		cyc(310);
		t_burst();
		t_faults();
		latch(1'h0);
		latch(1'h1);
		end_sim();
	end

	initial begin
		#200000;
		error_cnt++;
		end_sim();
	end
endmodule // burst_mode_protection_ctrl_tb_top
